// ===== shared/timer16_regs.svh
// timer16_regs.svh: offsets, field positions, reset values of the timer
// assumes: included by bare name from shared/ on the include path
`ifndef TIMER16_REGS_SVH
`define TIMER16_REGS_SVH

// register offsets on the plain register port
`define TMR_ADDR_COUNT_LOW 4'h0
`define TMR_ADDR_COUNT_HIGH 4'h1
`define TMR_ADDR_CONTROL 4'h2
`define TMR_ADDR_FLAGS 4'h3
`define TMR_ADDR_ENABLES 4'h4
`define TMR_ADDR_OSC_CONTROL 4'h5

// timer_control field positions
`define TMR_CTL_RUN 0
`define TMR_CTL_CLK_SRC 1
`define TMR_CTL_SYNC_BYP 2
`define TMR_CTL_XOSC_EN 3
`define TMR_CTL_PS_LO 4
`define TMR_CTL_PS_HI 5
`define TMR_CTL_SEC_ACT 6
`define TMR_CTL_WIDE 7

// oscillator_control field positions
`define TMR_OSC_SCS_LO 0
`define TMR_OSC_SCS_HI 1
`define TMR_OSC_IDLE 7

// field values and reset values
`define TMR_SCS_SECONDARY 2'h1
`define TMR_CONTROL_RESET 8'h00
`define TMR_OSC_RESET 8'h00
`define TMR_COUNT_RESET 16'h0000

`endif

// ===== shared/timer16_pkg.sv
// timer16_pkg: types shared by the timer design and its bench
// assumes: compiled before any file that imports it
`default_nettype none

package timer16_pkg;

  // power state of the device as seen by the timer
  typedef enum logic [1:0] {
    PWR_PRIMARY_RUN,
    PWR_SECONDARY_RUN,
    PWR_SECONDARY_IDLE,
    PWR_OTHER_SLEEP
  } power_state_t;

endpackage : timer16_pkg

`default_nettype wire

// ===== rtl/timer16.sv
// timer16: 16-bit up timer/counter with prescaler, wide access mode,
// compare-trigger reset, overflow flag and secondary clock status
// assumes: one clock core_clk, pins and strobes synchronous to it,
// quarter-rate instruction tick made here from core_clk
//
// Contract
// - source 0 counts each instruction cycle
// - source 1 counts rising external edges
// - enabled timer makes pins inputs reading zero
// - wide mode high address hits buffer
// - low read copies live high byte
// - low write loads high from buffer
// - only low writes clear prescaler
// - crystal runs whenever enabled, all modes
// - select 01 enters secondary run state
// - sleep without idle select: secondary idle
// - active bit set only on secondary clock
// - count wraps FFFFh to 0000h, sets flag
// - interrupt request only while enabled
// - compare trigger resets the count
// - trigger reset not for asynchronous counting
// - software write beats trigger reset
// - trigger reset never sets overflow flag
// - second unit trigger starts conversion
// - active bit zero for other sources
//
// The strobed register port and the register addresses were chosen for this implementation.
`include "timer16_regs.svh"
`default_nettype none

module timer16
  import timer16_pkg::*;
#(
  parameter int unsigned INSTR_DIV = 4 // core clocks per instruction cycle
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic ext_clock_pin,
  input wire logic crystal_in_pin,
  input wire logic [1:0] port_c_direction,
  input wire logic [1:0] port_c_pin_in,
  output logic [1:0] port_c_read,
  output logic [1:0] port_c_oe,
  output logic crystal_osc_run,
  input wire logic compare_trigger,
  input wire logic compare_uses_timer,
  input wire logic second_unit_trigger,
  input wire logic adc_enabled,
  output logic adc_start,
  input wire logic sleep_exec,
  input wire logic fail_safe_switch,
  output power_state_t power_state,
  output logic overflow_irq
);

  ////////////////////////////////////////////////////////////////////
  // registers

  logic [7:0] control_q; // timer_control, bit 6 unused here
  logic [7:0] osc_control_q; // oscillator_control
  logic [15:0] count_q; // live count
  logic [7:0] high_buf_q; // high byte holding buffer
  logic [7:0] rdata_q; // read data register
  logic overflow_flag_q; // sticky overflow flag
  logic overflow_irq_enable_q; // overflow interrupt enable
  logic [2:0] prescale_q; // prescaler count
  logic [1:0] instr_cnt_q; // instruction cycle divider
  logic ext_s1_q; // synchroniser first stage
  logic ext_s2_q; // synchroniser second stage
  logic ext_prev_q; // previous synchronised level
  logic raw_prev_q; // previous raw level, bypass path
  power_state_t power_state_q; // current power state

  // decoded control fields
  logic run_en;
  logic clk_src;
  logic sync_byp;
  logic xosc_en;
  logic wide_en;
  logic [1:0] ps_sel;
  assign run_en = control_q[`TMR_CTL_RUN];
  assign clk_src = control_q[`TMR_CTL_CLK_SRC];
  assign sync_byp = control_q[`TMR_CTL_SYNC_BYP];
  assign xosc_en = control_q[`TMR_CTL_XOSC_EN];
  assign wide_en = control_q[`TMR_CTL_WIDE];
  assign ps_sel = control_q[`TMR_CTL_PS_HI:`TMR_CTL_PS_LO];

  // access strobes
  logic wr_low, wr_high, rd_low, wr_ctl;
  assign wr_low = reg_wr && reg_addr == `TMR_ADDR_COUNT_LOW;
  assign wr_high = reg_wr && reg_addr == `TMR_ADDR_COUNT_HIGH;
  assign rd_low = reg_rd && reg_addr == `TMR_ADDR_COUNT_LOW;
  assign wr_ctl = reg_wr && reg_addr == `TMR_ADDR_CONTROL;

  ////////////////////////////////////////////////////////////////////
  // clock source selection

  // external source: crystal when enabled, else pin
  logic ext_raw;
  assign ext_raw = xosc_en ? crystal_in_pin : ext_clock_pin;

  // instruction cycle tick every INSTR_DIV core clocks
  logic instr_tick;
  assign instr_tick = instr_cnt_q == 2'(INSTR_DIV - 1);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      instr_cnt_q <= 2'h0;
    end else if (instr_tick) begin
      instr_cnt_q <= 2'h0;
    end else begin
      instr_cnt_q <= instr_cnt_q + 2'h1;
    end
  end

  // two-flop synchroniser, then edge detect on second stage
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ext_s1_q <= 1'b0;
      ext_s2_q <= 1'b0;
      ext_prev_q <= 1'b0;
      raw_prev_q <= 1'b0;
    end else begin
      ext_s1_q <= ext_raw;
      ext_s2_q <= ext_s1_q;
      ext_prev_q <= ext_s2_q;
      raw_prev_q <= ext_raw;
    end
  end

  // rising edge, synchronised or bypassed path
  logic ext_rise;
  always_comb begin
    if (sync_byp) begin
      ext_rise = ext_raw && !raw_prev_q;
    end else begin
      ext_rise = ext_s2_q && !ext_prev_q;
    end
  end

  // one source tick per cycle, gated by run enable
  logic src_tick;
  assign src_tick = run_en && (clk_src ? ext_rise : instr_tick);

  ////////////////////////////////////////////////////////////////////
  // prescaler

  // prescale mask: ratio minus one for 1,2,4,8
  function automatic logic [2:0] ps_mask(input logic [1:0] sel);
    unique case (sel)
      2'h0: ps_mask = 3'h0;
      2'h1: ps_mask = 3'h1;
      2'h2: ps_mask = 3'h3;
      2'h3: ps_mask = 3'h7;
    endcase
  endfunction : ps_mask

  logic count_tick;
  assign count_tick = src_tick && prescale_q == ps_mask(ps_sel);

  // prescaler count, cleared by low byte writes only
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      prescale_q <= 3'h0;
    end else if (wr_low) begin
      prescale_q <= 3'h0;
    end else if (count_tick) begin
      prescale_q <= 3'h0;
    end else if (src_tick) begin
      prescale_q <= prescale_q + 3'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // counter

  // trigger reset only in timer or synchronised counter mode
  logic trig_reset;
  assign trig_reset = compare_trigger && compare_uses_timer
    && !(clk_src && sync_byp);

  logic wrap;
  assign wrap = count_tick && count_q == 16'hffff;

  // live count: writes first, then trigger, then increment
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      count_q <= `TMR_COUNT_RESET;
    end else if (wr_low) begin
      // wide mode loads both bytes together
      if (wide_en) begin
        count_q <= {high_buf_q, reg_wdata};
      end else begin
        count_q[7:0] <= reg_wdata;
      end
    end else if (wr_high && !wide_en) begin
      count_q[15:8] <= reg_wdata;
    end else if (trig_reset) begin
      count_q <= `TMR_COUNT_RESET;
    end else if (count_tick) begin
      count_q <= count_q + 16'h0001;
    end
  end

  // holding buffer, written from software or sampled on low read
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      high_buf_q <= 8'h00;
    end else if (wide_en && wr_high) begin
      high_buf_q <= reg_wdata;
    end else if (wide_en && rd_low) begin
      high_buf_q <= count_q[15:8];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // overflow flag and interrupt

  // flag set by wrap or by a flags write of 1; wrap set wins over software clear
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      overflow_flag_q <= 1'b0;
    end else if (wrap && !wr_low && !wr_high && !trig_reset) begin
      overflow_flag_q <= 1'b1;
    end else if (reg_wr && reg_addr == `TMR_ADDR_FLAGS) begin
      overflow_flag_q <= reg_wdata[0];
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      overflow_irq_enable_q <= 1'b0;
    end else if (reg_wr && reg_addr == `TMR_ADDR_ENABLES) begin
      overflow_irq_enable_q <= reg_wdata[0];
    end
  end

  assign overflow_irq = overflow_flag_q && overflow_irq_enable_q;

  ////////////////////////////////////////////////////////////////////
  // control and oscillator control registers

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      control_q <= `TMR_CONTROL_RESET;
    end else if (wr_ctl) begin
      control_q <= reg_wdata;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      osc_control_q <= `TMR_OSC_RESET;
    end else if (reg_wr && reg_addr == `TMR_ADDR_OSC_CONTROL) begin
      osc_control_q <= reg_wdata;
    end
  end

  // crystal runs while enabled, in any power state
  assign crystal_osc_run = xosc_en;

  ////////////////////////////////////////////////////////////////////
  // power state tracking

  logic [1:0] scs;
  assign scs = osc_control_q[`TMR_OSC_SCS_HI:`TMR_OSC_SCS_LO];

  // entry only on a write of select 01; a level test would re-enter
  // secondary run right after a fail-safe switch while select reads 01
  logic sel_sec_wr;
  assign sel_sec_wr = reg_wr && reg_addr == `TMR_ADDR_OSC_CONTROL
    && reg_wdata[`TMR_OSC_SCS_HI:`TMR_OSC_SCS_LO] == `TMR_SCS_SECONDARY;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      power_state_q <= PWR_PRIMARY_RUN;
    end else if (fail_safe_switch) begin
      power_state_q <= PWR_PRIMARY_RUN;
    end else begin
      unique case (power_state_q)
        PWR_PRIMARY_RUN, PWR_OTHER_SLEEP: begin
          if (sel_sec_wr) begin
            power_state_q <= PWR_SECONDARY_RUN;
          end else if (sleep_exec) begin
            power_state_q <= PWR_OTHER_SLEEP;
          end else begin
            power_state_q <= PWR_PRIMARY_RUN;
          end
        end
        PWR_SECONDARY_RUN: begin
          if (scs != `TMR_SCS_SECONDARY) begin
            power_state_q <= PWR_PRIMARY_RUN;
          end else if (sleep_exec && !osc_control_q[`TMR_OSC_IDLE]) begin
            power_state_q <= PWR_SECONDARY_IDLE;
          end
        end
        PWR_SECONDARY_IDLE: begin
          if (scs != `TMR_SCS_SECONDARY) begin
            power_state_q <= PWR_PRIMARY_RUN;
          end
        end
      endcase
    end
  end

  assign power_state = power_state_q;

  // secondary clock active status
  logic sec_active;
  assign sec_active = power_state_q == PWR_SECONDARY_RUN
    || power_state_q == PWR_SECONDARY_IDLE;

  ////////////////////////////////////////////////////////////////////
  // pins and conversion start

  // enabled timer forces both pins to inputs reading zero
  assign port_c_oe = run_en ? 2'h0 : ~port_c_direction;
  assign port_c_read = run_en ? 2'h0 : port_c_pin_in;

  // second unit trigger starts a conversion when enabled
  assign adc_start = second_unit_trigger && adc_enabled;

  ////////////////////////////////////////////////////////////////////
  // read data, one cycle after the strobe

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rdata_q <= 8'h00;
    end else if (reg_rd) begin
      unique case (reg_addr)
        `TMR_ADDR_COUNT_LOW: rdata_q <= count_q[7:0];
        `TMR_ADDR_COUNT_HIGH: rdata_q <= wide_en ? high_buf_q
          : count_q[15:8];
        `TMR_ADDR_CONTROL: rdata_q <= {control_q[7], sec_active,
          control_q[5:0]};
        `TMR_ADDR_FLAGS: rdata_q <= {7'h00, overflow_flag_q};
        `TMR_ADDR_ENABLES: rdata_q <= {7'h00, overflow_irq_enable_q};
        `TMR_ADDR_OSC_CONTROL: rdata_q <= osc_control_q;
        default: rdata_q <= 8'h00;
      endcase
    end else begin
      rdata_q <= 8'h00;
    end
  end

  assign reg_rdata = rdata_q;

endmodule : timer16

`default_nettype wire

// ===== dv/timer16_monitor.sv
// timer16_monitor: port-level checks of the timer
// assumes: bound to timer16, one clock core_clk, rst async high
`default_nettype none

module timer16_monitor
  import timer16_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic [1:0] port_c_direction,
  input wire logic [1:0] port_c_read,
  input wire logic [1:0] port_c_oe,
  input wire logic crystal_osc_run,
  input wire logic second_unit_trigger,
  input wire logic adc_enabled,
  input wire logic adc_start,
  input wire logic sleep_exec,
  input wire logic fail_safe_switch,
  input wire power_state_t power_state,
  input wire logic overflow_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  ////////////////////////////////////////////////////////////////////////
  logic ie_q; // shadow of irq enable
  logic idle_q; // shadow of idle select
  // shadows follow register writes
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ie_q <= 1'b0;
      idle_q <= 1'b0;
    end else if (reg_wr && reg_addr == 4'h4) begin
      ie_q <= reg_wdata[0];
    end else if (reg_wr && reg_addr == 4'h5) begin
      idle_q <= reg_wdata[7];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // select written to secondary crystal
  sequence sel_sec_s;
    reg_wr && reg_addr == 4'h5 && reg_wdata[1:0] == 2'h1 &&
      !fail_safe_switch && !sleep_exec;
  endsequence
  // sleep taken while on the crystal
  sequence sleep_s;
    power_state == PWR_SECONDARY_RUN && sleep_exec && !idle_q &&
      !fail_safe_switch && !(reg_wr && reg_addr == 4'h5);
  endsequence

  sec_run_entry_a: assert property (sel_sec_s |-> ##[1:2]
    power_state == PWR_SECONDARY_RUN) else $error("no secondary run");
  sec_idle_entry_a: assert property (sleep_s |=>
    power_state == PWR_SECONDARY_IDLE) else $error("no secondary idle");
  fail_safe_a: assert property (fail_safe_switch |=>
    power_state == PWR_PRIMARY_RUN) else $error("fail-safe ignored");
  active_bit_a: assert property (reg_rd && reg_addr == 4'h2 |=>
    reg_rdata[6] == ($past(power_state) inside {PWR_SECONDARY_RUN,
    PWR_SECONDARY_IDLE})) else $error("active bit wrong");
  crystal_run_a: assert property (reg_wr && reg_addr == 4'h2 |=>
    crystal_osc_run == $past(reg_wdata[3])) else $error("crystal run");
  irq_mask_a: assert property (!ie_q |-> !overflow_irq)
    else $error("irq while masked");
  flag_read_a: assert property (reg_rd && reg_addr == 4'h3 && ie_q
    |=> reg_rdata[0] == $past(overflow_irq)) else $error("flag read");
  pin_zero_a: assert property (port_c_oe != ~port_c_direction |->
    port_c_read == 2'h0) else $error("pins read nonzero");
  adc_start_a: assert property (adc_start ==
    (second_unit_trigger && adc_enabled)) else $error("adc start");
  read_idle_a: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data not idle");
endmodule : timer16_monitor

bind timer16 timer16_monitor u_mon (.core_clk, .rst, .reg_addr,
  .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .port_c_direction,
  .port_c_read, .port_c_oe, .crystal_osc_run, .second_unit_trigger,
  .adc_enabled, .adc_start, .sleep_exec, .fail_safe_switch,
  .power_state, .overflow_irq);

`default_nettype wire

// ===== dv/timer16_bench.sv
// timer16_bench: self-checking bench of the timer
// assumes: package compiled first, checker bound by its own file
`default_nettype none

module timer16_bench import timer16_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk, rst, reg_wr, reg_rd, ext_clock_pin, sleep_exec;
  logic compare_trigger, compare_uses_timer, second_unit_trigger;
  logic adc_enabled, adc_start, fail_safe_switch, overflow_irq;
  logic crystal_osc_run, crystal_in_pin;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, d, e;
  logic [1:0] port_c_direction, port_c_pin_in, port_c_read, port_c_oe;
  power_state_t power_state;
  int miscompares, total_checks;

  timer16 #(.INSTR_DIV(4)) u_dut (.core_clk, .rst, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .ext_clock_pin,
    .crystal_in_pin, .port_c_direction, .port_c_pin_in,
    .port_c_read, .port_c_oe, .crystal_osc_run, .compare_trigger,
    .compare_uses_timer, .second_unit_trigger, .adc_enabled,
    .adc_start, .sleep_exec, .fail_safe_switch, .power_state,
    .overflow_irq);

  ////////////////////////////////////////////////////////////////////////
  // clock, 10 ns period
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr

  // read data is taken in the cycle after the strobe
  task automatic rd(input logic [3:0] a);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    d = reg_rdata;
  endtask : rd

  task automatic chk(input logic [7:0] g, input logic [7:0] x);
    total_checks++;
    if (g !== x) begin
      miscompares++;
      $display("wrong value at %0t: got %h want %h", $time, g, x);
    end
  endtask : chk

  // count compare allowing one tick of phase slack
  task automatic near(input logic [7:0] g, input logic [7:0] x);
    total_checks++;
    if ((8'(g - x + 8'h01) <= 8'h02) !== 1'b1) begin
      miscompares++;
      $display("wrong value at %0t: count %h near %h", $time, g, x);
    end
  endtask : near

  task automatic give_verdict;
    if (miscompares == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : give_verdict

  ////////////////////////////////////////////////////////////////////////
  // internal tick through every prescale, then hold when stopped
  task automatic t_prescale;
    for (int p = 0; p < 4; p++) begin
      wr(4'h2, 8'h00);
      wr(4'h1, 8'h00);
      wr(4'h0, 8'h00);
      wr(4'h2, 8'(p * 16 + 1));
      repeat (160) @(posedge core_clk);
      wr(4'h2, 8'h00);
      rd(4'h0);
      near(d, 8'(40 >> p));
      e = d;
      repeat (20) @(posedge core_clk);
      rd(4'h0);
      chk(d, e);
    end
  endtask : t_prescale

  // five edges: synchronised pin, bypassed pin, then crystal
  task automatic t_external;
    for (int b = 0; b < 3; b++) begin
      wr(4'h0, 8'h00);
      wr(4'h2, b == 2 ? 8'h0b : (b ? 8'h07 : 8'h03));
      if (b == 2) begin
        repeat (20) @(posedge core_clk);
      end
      repeat (5) begin
        @(posedge core_clk);
        if (b == 2) begin
          crystal_in_pin <= 1'b1;
        end else begin
          ext_clock_pin <= 1'b1;
        end
        repeat (4) @(posedge core_clk);
        ext_clock_pin <= 1'b0;
        crystal_in_pin <= 1'b0;
        repeat (4) @(posedge core_clk);
      end
      wr(4'h2, 8'h00);
      rd(4'h0);
      chk(d, 8'h05);
    end
  endtask : t_external

  // wide mode goes through the high byte buffer
  task automatic t_wide;
    wr(4'h2, 8'h80);
    wr(4'h1, 8'h12);
    wr(4'h0, 8'h34);
    rd(4'h0);
    chk(d, 8'h34);
    rd(4'h1);
    chk(d, 8'h12);
    wr(4'h1, 8'h56);
    rd(4'h1);
    chk(d, 8'h56);
    rd(4'h0);
    rd(4'h1);
    chk(d, 8'h12);
    wr(4'h2, 8'h00);
  endtask : t_wide

  // wrap sets the flag, irq follows its enable
  task automatic t_wrap;
    wr(4'h1, 8'hff);
    wr(4'h0, 8'hfe);
    wr(4'h3, 8'h00);
    wr(4'h4, 8'h01);
    wr(4'h2, 8'h01);
    repeat (16) @(posedge core_clk);
    wr(4'h2, 8'h00);
    rd(4'h1);
    chk(d, 8'h00);
    rd(4'h3);
    chk(d, 8'h01);
    chk({7'h0, overflow_irq}, 8'h01);
    wr(4'h4, 8'h00);
    @(negedge core_clk);
    chk({7'h0, overflow_irq}, 8'h00);
  endtask : t_wrap

  // trigger clears the count, loses to a write
  task automatic t_trigger;
    wr(4'h0, 8'h10);
    wr(4'h3, 8'h00);
    @(posedge core_clk);
    compare_uses_timer <= 1'b1;
    compare_trigger <= 1'b1;
    @(posedge core_clk);
    compare_trigger <= 1'b0;
    rd(4'h0);
    chk(d, 8'h00);
    rd(4'h3);
    chk(d, 8'h00);
    @(posedge core_clk);
    reg_addr <= 4'h0;
    reg_wdata <= 8'h55;
    reg_wr <= 1'b1;
    compare_trigger <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    compare_trigger <= 1'b0;
    rd(4'h0);
    chk(d, 8'h55);
  endtask : t_trigger

  // secondary run, idle, fail-safe return
  task automatic t_power;
    wr(4'h5, 8'h01);
    rd(4'h2);
    chk(8'(d[6]), 8'h01);
    @(posedge core_clk);
    sleep_exec <= 1'b1;
    @(posedge core_clk);
    sleep_exec <= 1'b0;
    @(negedge core_clk);
    chk(8'(power_state), 8'(PWR_SECONDARY_IDLE));
    @(posedge core_clk);
    fail_safe_switch <= 1'b1;
    @(posedge core_clk);
    fail_safe_switch <= 1'b0;
    @(negedge core_clk);
    chk(8'(power_state), 8'(PWR_PRIMARY_RUN));
    rd(4'h2);
    chk(8'(d[6]), 8'h00);
    wr(4'h5, 8'h00);
    rd(4'h2);
    chk(8'(d[6]), 8'h00);
    @(posedge core_clk);
    sleep_exec <= 1'b1;
    @(posedge core_clk);
    sleep_exec <= 1'b0;
    @(negedge core_clk);
    chk(8'(power_state), 8'(PWR_OTHER_SLEEP));
  endtask : t_power

  // pins, crystal enable and conversion start
  task automatic t_pins;
    @(posedge core_clk);
    port_c_direction <= 2'b01;
    port_c_pin_in <= 2'b11;
    wr(4'h2, 8'h09);
    @(negedge core_clk);
    chk(8'({port_c_read, port_c_oe}), 8'h00);
    chk(8'(crystal_osc_run), 8'h01);
    wr(4'h2, 8'h00);
    @(negedge core_clk);
    chk(8'(port_c_oe), 8'h02);
    chk(8'(port_c_read), 8'h03);
    @(posedge core_clk);
    second_unit_trigger <= 1'b1;
    adc_enabled <= 1'b1;
    @(negedge core_clk);
    chk(8'(adc_start), 8'h01);
    @(posedge core_clk);
    adc_enabled <= 1'b0;
    @(negedge core_clk);
    chk(8'(adc_start), 8'h00);
    @(posedge core_clk);
    second_unit_trigger <= 1'b0;
  endtask : t_pins

  ////////////////////////////////////////////////////////////////////////
  initial begin
    {rst, reg_wr, reg_rd, ext_clock_pin, sleep_exec} = 5'h10;
    {compare_trigger, compare_uses_timer, second_unit_trigger} = 3'h0;
    {adc_enabled, fail_safe_switch, reg_addr, reg_wdata} = 14'h0;
    {port_c_direction, port_c_pin_in, crystal_in_pin} = 5'h00;
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    rd(4'h2);
    chk(d, 8'h00);
    rd(4'hf);
    chk(d, 8'h00);
    t_prescale();
    t_external();
    t_wide();
    t_wrap();
    t_trigger();
    t_power();
    t_pins();
    give_verdict();
  end

  // hang guard, several times the expected run
  initial begin
    repeat (20000) @(posedge core_clk);
    miscompares++;
    give_verdict();
  end
endmodule : timer16_bench

`default_nettype wire
